/* File: logic/ctrb_consts.vh */
// Constants for the converter trim register bank: register indices,
// entry slots, field widths, control bit positions and reset values.
// Assumes a single clock domain and a classic Wishbone register port.
//
// Contract
// - each timing trim sets the sampling instant of its own core, and its factory value can be read and rewritten.
// - an 8-bit read/write timing trim for core B in dual mode is loaded from fuse storage at power-up.
// - an 8-bit timing trim for core A, interleaved with foreground calibration on input A, is fuse loaded.
// - an 8-bit timing trim for core B, interleaved with foreground calibration on input A, is fuse loaded.
// - an 8-bit timing trim for core A, interleaved with foreground calibration on input B, is fuse loaded.
// - an 8-bit timing trim for core B, interleaved with foreground calibration on input B, is fuse loaded.
// - every timing trim fills all eight bits, is fully readable and writable, and means the same thing.
// - a 12-bit offset goes to core A only when it samples input A on the 0-degree phase with calibration on.
// - a different 12-bit offset goes to core A when it samples input B on the 0-degree phase with calibration on.
// - each offset register keeps all 16 bits read/write, drives its low 12 to core A, and powers up from fuse storage.
`ifndef CTRB_CONSTS_VH
`define CTRB_CONSTS_VH

// -----------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define CTRB_IDX_A_TIM_DUAL 10'h310
`define CTRB_IDX_B_TIM_DUAL 10'h313
`define CTRB_IDX_A_TIM_ILV_A 10'h314
`define CTRB_IDX_B_TIM_ILV_A 10'h315
`define CTRB_IDX_A_TIM_ILV_B 10'h31A
`define CTRB_IDX_B_TIM_ILV_B 10'h31B
`define CTRB_IDX_A_OFS_P0_A 10'h344
`define CTRB_IDX_A_OFS_P0_B 10'h346
`define CTRB_IDX_MODE_CTRL 10'h3F0
`define CTRB_IDX_STATUS 10'h3F1

// -----------------------------------------------------------------
// storage slots, one per trim register, also the fuse word address
// -----------------------------------------------------------------
`define CTRB_SLOT_A_TIM_DUAL 3'h0
`define CTRB_SLOT_B_TIM_DUAL 3'h1
`define CTRB_SLOT_A_TIM_ILV_A 3'h2
`define CTRB_SLOT_B_TIM_ILV_A 3'h3
`define CTRB_SLOT_A_TIM_ILV_B 3'h4
`define CTRB_SLOT_B_TIM_ILV_B 3'h5
`define CTRB_SLOT_A_OFS_P0_A 3'h6
`define CTRB_SLOT_A_OFS_P0_B 3'h7
`define CTRB_NUM_TRIM 8
`define CTRB_SLOT_W 3

// -----------------------------------------------------------------
// field widths and masks
// -----------------------------------------------------------------
`define CTRB_TIM_W 8
`define CTRB_OFS_W 12
`define CTRB_REG_W 16
`define CTRB_TIM_MASK 16'h00FF
`define CTRB_OFS_MASK 16'hFFFF

// -----------------------------------------------------------------
// control and status bit positions, reset values
// -----------------------------------------------------------------
`define CTRB_CTL_ILV 0
`define CTRB_CTL_INSEL 1
`define CTRB_CTL_PH90 2
`define CTRB_CTL_FGCAL 3
`define CTRB_CTL_W 4
`define CTRB_CTL_RST 4'h0
`define CTRB_STS_DONE 0
`define CTRB_STS_BUSY 1
`define CTRB_TRIM_RST 16'h0000

`endif

/* File: logic/ctrb_fuse_loader.v */
// Fuse loader: after reset, reads every fuse word once and hands each
// to the trim bank as a one-cycle load strobe with its slot number.
// Assumes fuse storage on the same clock, data valid one cycle after read.
`timescale 1ns/1ps
`include "ctrb_consts.vh"

module ctrb_fuse_loader #(
  parameter NUM = `CTRB_NUM_TRIM
) (
  input wire clk_i,
  input wire rst_i,
  output wire fuse_rd_o,
  output wire [`CTRB_SLOT_W-1:0] fuse_addr_o,
  input wire [`CTRB_REG_W-1:0] fuse_data_i,
  output reg load_o,
  output reg [`CTRB_SLOT_W-1:0] load_slot_o,
  output reg [`CTRB_REG_W-1:0] load_data_o,
  output wire done_o
);

  // -----------------------------------------------------------------
  // states
  // -----------------------------------------------------------------
  localparam ST_READ = 2'b00;
  localparam ST_CAPT = 2'b01;
  localparam ST_DONE = 2'b10;
  localparam integer LAST_I = NUM - 1;
  localparam [`CTRB_SLOT_W-1:0] LAST = LAST_I[`CTRB_SLOT_W-1:0];

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [`CTRB_SLOT_W-1:0] cnt_r;

  assign fuse_rd_o = (state_r == ST_READ);
  assign fuse_addr_o = cnt_r;
  assign done_o = (state_r == ST_DONE);

  // next state: one read then one capture per fuse word
  always @* begin
    case (state_r)
      ST_READ: state_nxt = ST_CAPT;
      ST_CAPT: state_nxt = (cnt_r == LAST) ? ST_DONE : ST_READ;
      ST_DONE: state_nxt = ST_DONE;
      default: state_nxt = ST_READ;
    endcase
  end

  // sequencer and load strobe
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_READ;
      cnt_r <= {`CTRB_SLOT_W{1'b0}};
      load_o <= 1'b0;
      load_slot_o <= {`CTRB_SLOT_W{1'b0}};
      load_data_o <= `CTRB_TRIM_RST;
    end else begin
      state_r <= state_nxt;
      load_o <= (state_r == ST_CAPT);
      if (state_r == ST_CAPT) begin
        load_slot_o <= cnt_r;
        load_data_o <= fuse_data_i;
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule

/* File: logic/ctrb_trim_bank.v */
// Converter trim register bank: timing trims for both cores, offset trims for core A,
// fuse loaded after reset, rewritable over a classic Wishbone slave,
// and steered to the datapath by the operating mode.
// Assumes one 10 MHz clock, a synchronous reset and a fuse store on clk_i.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "ctrb_consts.vh"

module ctrb_trim_bank #(
  parameter AW = 12
) (
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [AW-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // fuse storage
  output wire fuse_rd_o,
  output wire [`CTRB_SLOT_W-1:0] fuse_addr_o,
  input wire [`CTRB_REG_W-1:0] fuse_data_i,
  // converter datapath
  output reg [`CTRB_TIM_W-1:0] a_core_timing_o,
  output reg [`CTRB_TIM_W-1:0] b_core_timing_o,
  output reg [`CTRB_OFS_W-1:0] a_core_offset_o,
  output reg a_core_offset_en_o,
  output reg trim_ready_o
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  wire [9:0] idx;
  wire req;
  wire done;
  wire load;
  wire [`CTRB_SLOT_W-1:0] load_slot;
  wire [`CTRB_REG_W-1:0] load_data;
  wire wr_commit;
  wire hit;
  wire [`CTRB_SLOT_W-1:0] slot;
  wire [`CTRB_REG_W-1:0] lane_mask;
  wire [`CTRB_REG_W-1:0] trim_flat [0:`CTRB_NUM_TRIM-1];
  reg [`CTRB_CTL_W-1:0] ctl_r;
  reg [31:0] rd_nxt;
  reg [`CTRB_TIM_W-1:0] a_tim_nxt;
  reg [`CTRB_TIM_W-1:0] b_tim_nxt;
  reg [`CTRB_OFS_W-1:0] a_ofs_nxt;
  reg a_ofs_en_nxt;
  reg [3:0] dec_r;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------

  // map a register index to {hit, slot}
  function [`CTRB_SLOT_W:0] slot_of;
    input [9:0] i;
    begin
      case (i)
        `CTRB_IDX_A_TIM_DUAL: slot_of = {1'b1, `CTRB_SLOT_A_TIM_DUAL};
        `CTRB_IDX_B_TIM_DUAL: slot_of = {1'b1, `CTRB_SLOT_B_TIM_DUAL};
        `CTRB_IDX_A_TIM_ILV_A: slot_of = {1'b1, `CTRB_SLOT_A_TIM_ILV_A};
        `CTRB_IDX_B_TIM_ILV_A: slot_of = {1'b1, `CTRB_SLOT_B_TIM_ILV_A};
        `CTRB_IDX_A_TIM_ILV_B: slot_of = {1'b1, `CTRB_SLOT_A_TIM_ILV_B};
        `CTRB_IDX_B_TIM_ILV_B: slot_of = {1'b1, `CTRB_SLOT_B_TIM_ILV_B};
        `CTRB_IDX_A_OFS_P0_A: slot_of = {1'b1, `CTRB_SLOT_A_OFS_P0_A};
        `CTRB_IDX_A_OFS_P0_B: slot_of = {1'b1, `CTRB_SLOT_A_OFS_P0_B};
        default: slot_of = {1'b0, `CTRB_SLOT_A_TIM_DUAL};
      endcase
    end
  endfunction

  // implemented bits per slot: timing trims 8, offset trims 16
  function [`CTRB_REG_W-1:0] slot_mask;
    input [`CTRB_SLOT_W-1:0] s;
    begin
      if (s == `CTRB_SLOT_A_OFS_P0_A || s == `CTRB_SLOT_A_OFS_P0_B) begin
        slot_mask = `CTRB_OFS_MASK;
      end else begin
        slot_mask = `CTRB_TIM_MASK;
      end
    end
  endfunction

  // -----------------------------------------------------------------
  // fuse load after reset
  // -----------------------------------------------------------------
  ctrb_fuse_loader #(
    .NUM(`CTRB_NUM_TRIM)
  ) i_ctrb_fuse_loader (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fuse_rd_o(fuse_rd_o),
    .fuse_addr_o(fuse_addr_o),
    .fuse_data_i(fuse_data_i),
    .load_o(load),
    .load_slot_o(load_slot),
    .load_data_o(load_data),
    .done_o(done)
  );

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------

  // word index and request; requests wait while fuses load
  assign idx = wb_adr_i[11:2];
  assign req = wb_cyc_i & wb_stb_i & done;
  assign {hit, slot} = slot_of(idx);
  // a write lands on the edge where the master sees ack
  assign wr_commit = req & wb_we_i & wb_ack_o;
  // byte lanes 0 and 1 carry the 16-bit register
  assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // one-cycle ack, dropped in the cycle after it is given
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  // -----------------------------------------------------------------
  // trim storage, one register per slot
  // -----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `CTRB_NUM_TRIM; g = g + 1) begin : g_trim
      localparam integer SLOT_I = g;
      reg [`CTRB_REG_W-1:0] val_r;
      wire [`CTRB_REG_W-1:0] msk;
      wire [`CTRB_REG_W-1:0] wmsk;
      assign msk = slot_mask(SLOT_I[`CTRB_SLOT_W-1:0]);
      assign wmsk = msk & lane_mask;
      assign trim_flat[g] = val_r;

      // fuse value first, then software may overwrite it
      always @(posedge clk_i) begin
        if (rst_i) begin
          val_r <= `CTRB_TRIM_RST;
        end else if (load && load_slot == SLOT_I[`CTRB_SLOT_W-1:0]) begin
          val_r <= load_data & msk;
        end else if (wr_commit && hit && slot == SLOT_I[`CTRB_SLOT_W-1:0]) begin
          val_r <= (val_r & ~wmsk) | (wb_dat_i[15:0] & wmsk);
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // mode control register
  // -----------------------------------------------------------------

  // interleave, input select, 90-degree phase, foreground calibration
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= `CTRB_CTL_RST;
    end else if (wr_commit && idx == `CTRB_IDX_MODE_CTRL && wb_sel_i[0]) begin
      ctl_r <= wb_dat_i[`CTRB_CTL_W-1:0];
    end
  end

  // -----------------------------------------------------------------
  // read path
  // -----------------------------------------------------------------

  // read mux; unmapped indices read zero
  always @* begin
    rd_nxt = 32'h00000000;
    if (hit) begin
      rd_nxt[`CTRB_REG_W-1:0] = trim_flat[slot];
    end else if (idx == `CTRB_IDX_MODE_CTRL) begin
      rd_nxt[`CTRB_CTL_W-1:0] = ctl_r;
    end else if (idx == `CTRB_IDX_STATUS) begin
      rd_nxt[`CTRB_STS_DONE] = done;
      rd_nxt[`CTRB_STS_BUSY] = ~done;
    end
  end

  // read data is captured as a read's ack rises and held until the next read
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (req && !wb_we_i && !wb_ack_o) begin
      wb_dat_o <= rd_nxt;
    end
  end

  // -----------------------------------------------------------------
  // mode selection toward the datapath
  // -----------------------------------------------------------------

  // decoded mode, kept for the selection below
  always @* begin
    dec_r = ctl_r;
  end

  // pick each core's timing trim and core A's offset from the mode
  always @* begin
    a_tim_nxt = trim_flat[`CTRB_SLOT_A_TIM_DUAL][`CTRB_TIM_W-1:0];
    b_tim_nxt = trim_flat[`CTRB_SLOT_B_TIM_DUAL][`CTRB_TIM_W-1:0];
    a_ofs_nxt = {`CTRB_OFS_W{1'b0}};
    a_ofs_en_nxt = 1'b0;
    if (dec_r[`CTRB_CTL_ILV] && dec_r[`CTRB_CTL_FGCAL]) begin
      if (!dec_r[`CTRB_CTL_INSEL]) begin
        a_tim_nxt = trim_flat[`CTRB_SLOT_A_TIM_ILV_A][`CTRB_TIM_W-1:0];
        b_tim_nxt = trim_flat[`CTRB_SLOT_B_TIM_ILV_A][`CTRB_TIM_W-1:0];
      end else begin
        a_tim_nxt = trim_flat[`CTRB_SLOT_A_TIM_ILV_B][`CTRB_TIM_W-1:0];
        b_tim_nxt = trim_flat[`CTRB_SLOT_B_TIM_ILV_B][`CTRB_TIM_W-1:0];
      end
    end
    if (dec_r[`CTRB_CTL_FGCAL] && !dec_r[`CTRB_CTL_PH90]) begin
      a_ofs_en_nxt = 1'b1;
      if (!dec_r[`CTRB_CTL_INSEL]) begin
        a_ofs_nxt = trim_flat[`CTRB_SLOT_A_OFS_P0_A][`CTRB_OFS_W-1:0];
      end else begin
        a_ofs_nxt = trim_flat[`CTRB_SLOT_A_OFS_P0_B][`CTRB_OFS_W-1:0];
      end
    end
  end

  // registered datapath values follow every mode or trim change
  always @(posedge clk_i) begin
    if (rst_i) begin
      a_core_timing_o <= {`CTRB_TIM_W{1'b0}};
      b_core_timing_o <= {`CTRB_TIM_W{1'b0}};
      a_core_offset_o <= {`CTRB_OFS_W{1'b0}};
      a_core_offset_en_o <= 1'b0;
      trim_ready_o <= 1'b0;
    end else begin
      a_core_timing_o <= a_tim_nxt;
      b_core_timing_o <= b_tim_nxt;
      a_core_offset_o <= a_ofs_nxt;
      a_core_offset_en_o <= a_ofs_en_nxt;
      trim_ready_o <= done;
    end
  end

endmodule

/* File: verif/ctrb_trim_bank_assertions.sv */
// Checker for the trim bank: bus handshake, fuse load and datapath gating.
// Assumes it is bound to ctrb_trim_bank and sees only that module's ports.
`timescale 1ns/1ps
`include "ctrb_consts.vh"
module ctrb_trim_bank_assertions #(
  parameter AW = 12
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [AW-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire fuse_rd_o,
  input wire [`CTRB_SLOT_W-1:0] fuse_addr_o,
  input wire [`CTRB_REG_W-1:0] fuse_data_i,
  input wire [`CTRB_TIM_W-1:0] a_core_timing_o,
  input wire [`CTRB_TIM_W-1:0] b_core_timing_o,
  input wire [`CTRB_OFS_W-1:0] a_core_offset_o,
  input wire a_core_offset_en_o,
  input wire trim_ready_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------
  // sequences and assertions
  // ---------------------------------------------------------------
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_load;
    !trim_ready_o ##[14:18] trim_ready_o;
  endsequence
  sequence s_wr_done;
    $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2) || $past(wb_ack_o && wb_we_i, 3);
  endsequence
  a_ack_pulse: assert property (wb_ack_o |-> s_ack_once) else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  a_ack_ready: assert property (wb_ack_o |-> ##[0:1] trim_ready_o) else $error("ack in load");
  a_load_time: assert property ($fell(rst_i) |-> s_load) else $error("load time wrong");
  a_ready_hold: assert property (trim_ready_o |=> trim_ready_o) else $error("ready dropped");
  a_fuse_quiet: assert property (trim_ready_o |-> !fuse_rd_o) else $error("fuse read late");
  a_ofs_gate: assert property (!a_core_offset_en_o |-> a_core_offset_o == 0) else $error("ofs leak");
  a_dat_cause: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i) else $error("dat moved");
  a_tim_cause: assert property (($changed(a_core_timing_o) || $changed(b_core_timing_o))
    && $past(trim_ready_o, 3) |-> s_wr_done) else $error("timing moved alone");
endmodule
bind ctrb_trim_bank ctrb_trim_bank_assertions #(.AW(AW)) i_ctrb_trim_bank_assertions (.*);

/* File: verif/tb_ctrb_trim_bank.sv */
// Testbench for the trim bank: fuse load, register access and mode steering.
// Assumes a 10 MHz clock and a fuse store answering one cycle after a read.
`timescale 1ns/1ps
`include "ctrb_consts.vh"
module tb_ctrb_trim_bank;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fuse_rd_o, trim_ready_o;
  logic a_core_offset_en_o;
  logic [11:0] wb_adr_i, a_core_offset_o;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [2:0] fuse_addr_o;
  logic [15:0] fuse_data_i, rnd;
  logic [7:0] a_core_timing_o, b_core_timing_o;
  logic [15:0] fuse_tab [8];
  logic [15:0] trim [8];
  logic [9:0] idx [8];
  logic [31:0] exp_q [$];
  int n_mismatch, n_tests, cyc_cnt;
  ctrb_trim_bank #(.AW(12)) i_ctrb_trim_bank (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fuse_rd_o(fuse_rd_o), .fuse_addr_o(fuse_addr_o), .fuse_data_i(fuse_data_i),
    .a_core_timing_o(a_core_timing_o), .b_core_timing_o(b_core_timing_o),
    .a_core_offset_o(a_core_offset_o), .a_core_offset_en_o(a_core_offset_en_o),
    .trim_ready_o(trim_ready_o));
  // ---------------------------------------------------------------
  // clock, fuse store, monitor, timeout
  // ---------------------------------------------------------------
  initial begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  // fuse word answers a read; otherwise the line keeps toggling
  always @(posedge clk_i) fuse_data_i <= fuse_rd_o ? fuse_tab[fuse_addr_o] : ~fuse_data_i;
  // read answers are matched against the oldest expectation
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      check(wb_dat_o, exp_q.size() > 0 ? exp_q.pop_front() : ~wb_dat_o);
    end
  end
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      n_mismatch++;
      conclude;
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [11:0] badr(input int i);
    return {idx[i], 2'b00};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(0, a, 32'h0, 4'hF);
  endtask
  task automatic dp(input logic [3:0] c);
    logic en;
    en = c[3] & ~c[2];
    check({24'h0, a_core_timing_o}, {24'h0, trim[(c[0] & c[3]) ? (c[1] ? 4 : 2) : 0][7:0]});
    check({24'h0, b_core_timing_o}, {24'h0, trim[(c[0] & c[3]) ? (c[1] ? 5 : 3) : 1][7:0]});
    check({31'h0, a_core_offset_en_o}, {31'h0, en});
    check({20'h0, a_core_offset_o}, en ? {20'h0, trim[c[1] ? 7 : 6][11:0]} : 32'h0);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_i = 1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {n_mismatch, n_tests, cyc_cnt} = '0;
    idx = '{`CTRB_IDX_A_TIM_DUAL, `CTRB_IDX_B_TIM_DUAL, `CTRB_IDX_A_TIM_ILV_A,
      `CTRB_IDX_B_TIM_ILV_A, `CTRB_IDX_A_TIM_ILV_B, `CTRB_IDX_B_TIM_ILV_B,
      `CTRB_IDX_A_OFS_P0_A, `CTRB_IDX_A_OFS_P0_B};
    rnd = 16'h000D;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      fuse_tab[i] = rnd;
      trim[i] = i < 6 ? rnd & 16'h00FF : rnd;
    end
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    // first read is issued while the fuse load still runs and must stall
    for (int i = 0; i < 8; i++) rd(badr(i), {16'h0, trim[i]});
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      bus(1, badr(i), {16'hFFFF, rnd}, 4'hF);
      trim[i] = i < 6 ? rnd & 16'h00FF : rnd;
      rd(badr(i), {16'h0, trim[i]});
    end
    rnd = lfsr(rnd);
    bus(1, badr(7), {16'h0, rnd}, 4'h2);
    trim[7][15:8] = rnd[15:8];
    rd(badr(7), {16'h0, trim[7]});
    bus(1, 12'h800, {16'h0, rnd}, 4'hF);
    rd(12'h800, 32'h0);
    for (int c = 0; c < 16; c++) begin
      bus(1, {`CTRB_IDX_MODE_CTRL, 2'b00}, c, 4'hF);
      rd({`CTRB_IDX_MODE_CTRL, 2'b00}, c);
      repeat (3) @(posedge clk_i);
      dp(c[3:0]);
    end
    // status reports load done and ignores writes
    bus(1, {`CTRB_IDX_STATUS, 2'b00}, 32'h0, 4'hF);
    rd({`CTRB_IDX_STATUS, 2'b00}, 32'h1 << `CTRB_STS_DONE);
    // a second reset brings the fuse values back over the software writes
    @(posedge clk_i);
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 8; i++) begin
      trim[i] = i < 6 ? fuse_tab[i] & 16'h00FF : fuse_tab[i];
      rd(badr(i), {16'h0, trim[i]});
    end
    rd({`CTRB_IDX_MODE_CTRL, 2'b00}, 32'h0);
    repeat (3) @(posedge clk_i);
    dp(4'h0);
    conclude;
  end
endmodule
